/* rpiso_top.sv */
// rpiso_top: timeout tracking and isolation for memory and cache protocols
// assumes: host requests and link responses synchronous to pclk;
// link_down is a level from the link layer
//
// The placing of the registers and register access over APB are this design's own decisions.
`timescale 1ns/10ps

// Notes on behaviour
// - While a protocol is isolated its traffic is not passed to the link.
// - Once isolated, pending and later requests get locally made answers.
// - With cache isolation enabled, link down always isolates cache.
// - With memory isolation enabled, link down always isolates memory.
// - A cache timeout isolates cache when software allows it.
// - A memory timeout isolates memory when software allows it.
// - Timeout and isolation reset disabled and are enabled per protocol.
// - An option forces the link down when a protocol enters isolation.
// - Entering isolation sends an interrupt or error message as enabled.
// - Status shows per protocol timeout, isolation and its cause.
// - Isolated memory reads are answered with poisoned data.
// - Isolated memory non-reads get a no-data completion.
// - Isolated writes and invalidates complete locally, data dropped.
// - Memory and cache isolation work independently.
// - Every outstanding host request is tracked for timeout and cleanup.
module rpiso_proto (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic tmo_en,
	input wire logic iso_en,
	input wire logic trig_tmo,
	input wire logic sw_clr,
	input wire logic link_down,
	input wire logic [rpiso_pkg::TMR_W-1:0] tmo_limit,
	input wire rpiso_pkg::rpiso_req_t host_req,
	output logic host_req_ready,
	output rpiso_pkg::rpiso_req_t link_req,
	input wire logic link_req_ready,
	input wire rpiso_pkg::rpiso_rsp_t link_rsp,
	output rpiso_pkg::rpiso_rsp_t host_rsp,
	output logic isolated,
	output logic iso_enter,
	output logic tmo_seen,
	output logic by_tmo,
	output logic by_ldn,
	output logic [rpiso_pkg::NTAG-1:0] pend
);
	localparam int NT = rpiso_pkg::NTAG;
	localparam int TW = rpiso_pkg::TAG_W;
	rpiso_pkg::rpiso_state_t state_reg, state_next;
	logic [NT-1:0] pend_reg, pend_next, rd_reg;
	logic [rpiso_pkg::TMR_W-1:0] age_reg [NT];
	rpiso_pkg::rpiso_rsp_t rsp_reg, rsp_next;
	logic tmo_reg, by_tmo_reg, by_ldn_reg;
	logic [NT-1:0] expired;
	logic any_tmo, trig, iso, fwd, new_local, iso_exit;
	logic [TW-1:0] flush_tag;
	logic flush_hit;

	// ===========================================================
	// forwarding and local answers
	assign iso = (state_reg == rpiso_pkg::ST_ISO);
	// forward only when not isolated
	assign fwd = host_req.valid && !iso && !pend_reg[host_req.tag];
	assign new_local = host_req.valid && iso;
	assign host_req_ready = iso || (link_req_ready && !pend_reg[host_req.tag]);
	always_comb begin
		link_req = host_req;
		link_req.valid = fwd;
	end

	// ===========================================================
	// per-tag age counters
	// they run with timeouts off, so enabling late may expire an old tag
	for (genvar i = 0; i < NT; i++) begin : g_age
		assign expired[i] = tmo_en && pend_reg[i] &&
			(age_reg[i] >= tmo_limit);
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				age_reg[i] <= '0;
			end else if (ce) begin
				if (fwd && link_req_ready && host_req.tag == TW'(i))
					age_reg[i] <= '0;
				else if (pend_reg[i] && !expired[i])
					age_reg[i] <= age_reg[i] + 1'b1;
			end
		end
	end
	assign any_tmo = |expired;
	// with isolation enabled link down always wins, timeout only when allowed
	assign trig = iso_en &&
		(link_down || (trig_tmo && any_tmo));
	assign iso_enter = !iso && trig;

	// ===========================================================
	// flush pick
	// lowest pending tag flushed one per cycle during isolation
	always_comb begin
		flush_tag = '0;
		flush_hit = 1'b0;
		for (int i = NT - 1; i >= 0; i--) begin
			if (pend_reg[i]) begin
				flush_tag = TW'(i);
				flush_hit = 1'b1;
			end
		end
	end

	// ===========================================================
	// isolation state machine
	always_comb begin
		state_next = state_reg;
		pend_next = pend_reg;
		rsp_next = '0;
		case (state_reg)
			rpiso_pkg::ST_RUN: begin
				if (trig)
					state_next = rpiso_pkg::ST_ISO;
				if (link_rsp.valid) begin
					pend_next[link_rsp.tag] = 1'b0;
					rsp_next = link_rsp;
				end
				if (fwd && link_req_ready)
					pend_next[host_req.tag] = 1'b1;
			end
			rpiso_pkg::ST_ISO: begin
				// link responses dropped; new requests answered first
				if (new_local) begin
					rsp_next.valid = 1'b1;
					rsp_next.tag = host_req.tag;
					rsp_next.poison = host_req.is_read;
					rsp_next.has_data = host_req.is_read;
					rsp_next.data = host_req.is_read ?
						rpiso_pkg::POISON_DATA : '0;
				end else if (flush_hit) begin
					pend_next[flush_tag] = 1'b0;
					rsp_next.valid = 1'b1;
					rsp_next.tag = flush_tag;
					rsp_next.poison = rd_reg[flush_tag];
					rsp_next.has_data = rd_reg[flush_tag];
					rsp_next.data = rd_reg[flush_tag] ?
						rpiso_pkg::POISON_DATA : '0;
				end
				if (sw_clr && !flush_hit && !trig)
					state_next = rpiso_pkg::ST_RUN;
			end
			default: state_next = rpiso_pkg::ST_RUN;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= rpiso_pkg::ST_RUN;
			pend_reg <= '0;
			rd_reg <= '0;
			rsp_reg <= '0;
		end else if (ce) begin
			state_reg <= state_next;
			pend_reg <= pend_next;
			rsp_reg <= rsp_next;
			if (fwd && link_req_ready)
				rd_reg[host_req.tag] <= host_req.is_read;
		end
	end

	// ===========================================================
	// status
	// the clear that ends isolation also drops the cause bits
	assign iso_exit = iso && (state_next == rpiso_pkg::ST_RUN);
	// sticky status: set wins over clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tmo_reg <= 1'b0;
			by_tmo_reg <= 1'b0;
			by_ldn_reg <= 1'b0;
		end else if (ce) begin
			if (any_tmo)
				tmo_reg <= 1'b1;
			else if (sw_clr)
				tmo_reg <= 1'b0;
			if (iso_enter) begin
				by_ldn_reg <= link_down;
				by_tmo_reg <= !link_down;
			end else if ((sw_clr && !iso) || iso_exit) begin
				by_ldn_reg <= 1'b0;
				by_tmo_reg <= 1'b0;
			end
		end
	end
	assign host_rsp = rsp_reg;
	assign isolated = iso;
	assign tmo_seen = tmo_reg;
	assign by_tmo = by_tmo_reg;
	assign by_ldn = by_ldn_reg;
	assign pend = pend_reg;
endmodule : rpiso_proto

module rpiso_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic link_down,
	output logic force_link_down,
	input wire rpiso_pkg::rpiso_req_t mem_host_req,
	output logic mem_host_req_ready,
	output rpiso_pkg::rpiso_req_t mem_link_req,
	input wire logic mem_link_req_ready,
	input wire rpiso_pkg::rpiso_rsp_t mem_link_rsp,
	output rpiso_pkg::rpiso_rsp_t mem_host_rsp,
	input wire rpiso_pkg::rpiso_req_t cache_host_req,
	output logic cache_host_req_ready,
	output rpiso_pkg::rpiso_req_t cache_link_req,
	input wire logic cache_link_req_ready,
	input wire rpiso_pkg::rpiso_rsp_t cache_link_rsp,
	output rpiso_pkg::rpiso_rsp_t cache_host_rsp,
	output logic msi_req,
	output logic err_cor_req,
	output logic irq
);
	localparam int PS = rpiso_pkg::P_STRIDE;
	logic [31:0] ctrl_reg, ien_reg, tmo_reg;
	logic [31:0] stat_sticky_reg, stat_word, ev_word;
	logic msi_reg, err_reg;
	logic wr, rd, hit_ctrl, hit_stat, hit_ien, hit_iclr, hit_tmo, hit_pend;
	logic mapped;
	logic [1:0] iso, enter, tmo_s, btmo, bldn, clr;
	logic [rpiso_pkg::NTAG-1:0] pend_m, pend_c;
	logic [1:0] tmo_d_reg;

	// ===========================================================
	// apb decode, zero wait states
	assign wr = psel && penable && pwrite && ce;
	assign rd = psel && !pwrite;
	assign hit_ctrl = paddr == rpiso_pkg::OFF_CTRL;
	assign hit_stat = paddr == rpiso_pkg::OFF_STAT;
	assign hit_ien = paddr == rpiso_pkg::OFF_IEN;
	assign hit_iclr = paddr == rpiso_pkg::OFF_ICLR;
	assign hit_tmo = paddr == rpiso_pkg::OFF_TMO;
	assign hit_pend = paddr == rpiso_pkg::OFF_PEND;
	assign mapped = hit_ctrl | hit_stat | hit_ien | hit_iclr | hit_tmo |
		hit_pend;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
	// clear strobe per protocol: ctrl clear bit acts on the write only, yet stays stored in ctrl_reg
	assign clr[0] = wr && hit_ctrl && pwdata[rpiso_pkg::C_CLR];
	assign clr[1] = wr && hit_ctrl && pwdata[PS + rpiso_pkg::C_CLR];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= rpiso_pkg::CTRL_RST;
			ien_reg <= '0;
			tmo_reg <= rpiso_pkg::TIMEOUT_CYC_DEF;
		end else if (wr) begin
			if (hit_ctrl)
				ctrl_reg <= pwdata;
			if (hit_ien)
				ien_reg <= pwdata;
			if (hit_tmo)
				tmo_reg <= pwdata;
		end
	end

	// ===========================================================
	// the two protocols, separate except for the shared link_down and timeout limit
	rpiso_proto u_mem (
		.pclk(pclk), .presetn(presetn), .ce(ce),
		.tmo_en(ctrl_reg[rpiso_pkg::C_TMO_EN]),
		.iso_en(ctrl_reg[rpiso_pkg::C_ISO_EN]),
		.trig_tmo(ctrl_reg[rpiso_pkg::C_TRIG_TMO]),
		.sw_clr(clr[0]), .link_down(link_down), .tmo_limit(tmo_reg),
		.host_req(mem_host_req), .host_req_ready(mem_host_req_ready),
		.link_req(mem_link_req), .link_req_ready(mem_link_req_ready),
		.link_rsp(mem_link_rsp), .host_rsp(mem_host_rsp),
		.isolated(iso[0]), .iso_enter(enter[0]), .tmo_seen(tmo_s[0]),
		.by_tmo(btmo[0]), .by_ldn(bldn[0]), .pend(pend_m)
	);
	rpiso_proto u_cache (
		.pclk(pclk), .presetn(presetn), .ce(ce),
		.tmo_en(ctrl_reg[PS + rpiso_pkg::C_TMO_EN]),
		.iso_en(ctrl_reg[PS + rpiso_pkg::C_ISO_EN]),
		.trig_tmo(ctrl_reg[PS + rpiso_pkg::C_TRIG_TMO]),
		.sw_clr(clr[1]), .link_down(link_down), .tmo_limit(tmo_reg),
		.host_req(cache_host_req), .host_req_ready(cache_host_req_ready),
		.link_req(cache_link_req), .link_req_ready(cache_link_req_ready),
		.link_rsp(cache_link_rsp), .host_rsp(cache_host_rsp),
		.isolated(iso[1]), .iso_enter(enter[1]), .tmo_seen(tmo_s[1]),
		.by_tmo(btmo[1]), .by_ldn(bldn[1]), .pend(pend_c)
	);

	// ===========================================================
	// status and interrupts
	always_comb begin
		stat_word = '0;
		ev_word = '0;
		for (int p = 0; p < 2; p++) begin
			stat_word[p*PS + rpiso_pkg::S_TMO] = tmo_s[p];
			stat_word[p*PS + rpiso_pkg::S_ISO] = iso[p];
			stat_word[p*PS + rpiso_pkg::S_BY_TMO] = btmo[p];
			stat_word[p*PS + rpiso_pkg::S_BY_LDN] = bldn[p];
			ev_word[p*PS + rpiso_pkg::S_ISO] = enter[p];
			ev_word[p*PS + rpiso_pkg::S_TMO] = tmo_s[p] && !tmo_d_reg[p];
		end
	end
	// timeout event is the rising edge of the seen flag
	// a level would refill the sticky bit after every clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			tmo_d_reg <= '0;
		else if (ce)
			tmo_d_reg <= tmo_s;
	end
	// sticky event bits, set wins over clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			stat_sticky_reg <= '0;
		else if (ce)
			stat_sticky_reg <= ev_word |
				(stat_sticky_reg & ~((wr && hit_iclr) ? pwdata : '0));
	end
	assign irq = |(stat_sticky_reg & ien_reg);

	// one-cycle message requests on entry
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			msi_reg <= 1'b0;
			err_reg <= 1'b0;
		end else if (ce) begin
			msi_reg <= (enter[0] && ctrl_reg[rpiso_pkg::C_MSI_EN]) ||
				(enter[1] && ctrl_reg[PS + rpiso_pkg::C_MSI_EN]);
			err_reg <= (enter[0] && ctrl_reg[rpiso_pkg::C_ERR_EN]) ||
				(enter[1] && ctrl_reg[PS + rpiso_pkg::C_ERR_EN]);
		end
	end
	assign msi_req = msi_reg;
	assign err_cor_req = err_reg;
	// held while the protocol stays isolated
	assign force_link_down = (iso[0] && ctrl_reg[rpiso_pkg::C_LDN_EN]) ||
		(iso[1] && ctrl_reg[PS + rpiso_pkg::C_LDN_EN]);

	assign prdata = !rd ? '0 :
		hit_ctrl ? ctrl_reg :
		hit_stat ? stat_word :
		hit_ien ? ien_reg :
		hit_tmo ? tmo_reg :
		hit_pend ? {pend_c, pend_m} :
		hit_iclr ? stat_sticky_reg : '0;
endmodule : rpiso_top

/* rpiso_pkg.sv */
// rpiso_pkg: constants, types and register map for root port isolation
// assumes: apb slave at 40 MHz pclk, one clock domain
package rpiso_pkg;
	localparam int TAG_W = 4;
	localparam int NTAG = 16;
	localparam int TMR_W = 32;
	localparam int CLK_MHZ = 40;
	localparam int TIMEOUT_US = 50;
	localparam logic [TMR_W-1:0] TIMEOUT_CYC_DEF =
		TMR_W'(TIMEOUT_US * CLK_MHZ);
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STAT = 8'h04;
	localparam logic [7:0] OFF_IEN = 8'h08;
	localparam logic [7:0] OFF_ICLR = 8'h0c;
	localparam logic [7:0] OFF_TMO = 8'h10;
	localparam logic [7:0] OFF_PEND = 8'h14;
	// control bits, per protocol p: base p*8
	localparam int C_TMO_EN = 0;
	localparam int C_ISO_EN = 1;
	localparam int C_TRIG_TMO = 2;
	localparam int C_LDN_EN = 3;
	localparam int C_MSI_EN = 4;
	localparam int C_ERR_EN = 5;
	localparam int C_CLR = 6;
	localparam int P_STRIDE = 8;
	// status bits per protocol p: base p*8
	localparam int S_TMO = 0;
	localparam int S_ISO = 1;
	localparam int S_BY_TMO = 2;
	localparam int S_BY_LDN = 3;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam int P_MEM = 0;
	localparam int P_CACHE = 1;
	localparam logic [31:0] POISON_DATA = 32'hdead_beef;
	typedef struct packed {
		logic valid;
		logic [TAG_W-1:0] tag;
		logic is_read;
		logic [31:0] addr;
		logic [31:0] data;
	} rpiso_req_t;
	typedef struct packed {
		logic valid;
		logic [TAG_W-1:0] tag;
		logic poison;
		logic has_data;
		logic [31:0] data;
	} rpiso_rsp_t;
	typedef enum logic [1:0] {
		ST_RUN = 2'b01,
		ST_ISO = 2'b10
	} rpiso_state_t;
endpackage : rpiso_pkg

/* rpiso_monitor.sv */
// rpiso_monitor: port-level checks for rpiso_top
// assumes: bound to rpiso_top, one pclk domain
`timescale 1ns/10ps
module rpiso_monitor (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic force_link_down,
	input wire rpiso_pkg::rpiso_req_t mem_host_req,
	input wire logic mem_host_req_ready,
	input wire rpiso_pkg::rpiso_req_t mem_link_req,
	input wire rpiso_pkg::rpiso_rsp_t mem_host_rsp,
	input wire rpiso_pkg::rpiso_req_t cache_host_req,
	input wire logic cache_host_req_ready,
	input wire rpiso_pkg::rpiso_req_t cache_link_req,
	input wire rpiso_pkg::rpiso_rsp_t cache_host_rsp,
	input wire logic msi_req
);
	// ========
	// helpers
	logic apb_wr;
	logic mem_take;
	logic cache_take;
	assign apb_wr = psel && penable && pwrite;
	// taken but not forwarded: must be answered locally
	assign mem_take = mem_host_req.valid && mem_host_req_ready
		&& !mem_link_req.valid;
	assign cache_take = cache_host_req.valid && cache_host_req_ready
		&& !cache_link_req.valid;
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// ========
	// checks
	AST_MEM_ISO_RD: assert property (
		mem_take && mem_host_req.is_read |=> mem_host_rsp.valid
		&& mem_host_rsp.poison && mem_host_rsp.tag == $past(mem_host_req.tag))
		else $error("local read answer missing");
	AST_CACHE_ISO_WR: assert property (
		cache_take && !cache_host_req.is_read |=> cache_host_rsp.valid
		&& !cache_host_rsp.has_data && !cache_host_rsp.poison)
		else $error("local write answer wrong");
	AST_POISON_FMT: assert property (
		mem_host_rsp.valid && mem_host_rsp.poison |-> mem_host_rsp.has_data
		&& mem_host_rsp.data == rpiso_pkg::POISON_DATA)
		else $error("poison answer malformed");
	AST_NODATA_CLEAN: assert property (
		mem_host_rsp.valid && !mem_host_rsp.has_data |-> !mem_host_rsp.poison)
		else $error("no-data answer poisoned");
	AST_FWD_SAME: assert property (
		mem_link_req.valid |-> mem_host_req.valid
		&& mem_link_req.tag == mem_host_req.tag
		&& mem_link_req.addr == mem_host_req.addr)
		else $error("forwarded request altered");
	AST_ISO_NO_FWD: assert property (
		mem_host_rsp.valid && mem_host_rsp.poison |-> !mem_link_req.valid)
		else $error("traffic passed while isolated");
	AST_MSI_PULSE: assert property (
		msi_req |=> !msi_req)
		else $error("interrupt request held");
	AST_LDN_HOLD: assert property (
		$fell(force_link_down) |-> $past(apb_wr))
		else $error("link-down force dropped alone");
endmodule : rpiso_monitor

/* rpiso_link_model.sv */
// rpiso_link_model: far-end device answering link requests
// assumes: one request in flight, answer lat+1 cycles after acceptance
`timescale 1ns/10ps
module rpiso_link_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire rpiso_pkg::rpiso_req_t req,
	output logic ready,
	output rpiso_pkg::rpiso_rsp_t rsp,
	input wire logic [3:0] lat,
	input wire logic mute
);
	// ========
	// one slot
	logic [4:0] cnt_reg;
	rpiso_pkg::rpiso_req_t held_reg;
	// mute swallows the request so the host has to time out
	assign ready = !cnt_reg[4];
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_reg <= 5'h00;
			held_reg <= '0;
			rsp <= '0;
		end else begin
			rsp.valid <= 1'b0;
			// idle data keeps moving, stale words never look valid
			rsp.data <= ~rsp.data;
			if (req.valid && ready) begin
				cnt_reg <= {!mute, lat};
				held_reg <= req;
			end else if (cnt_reg[4] && cnt_reg[3:0] != 4'h0) begin
				cnt_reg[3:0] <= cnt_reg[3:0] - 4'h1;
			end else if (cnt_reg[4]) begin
				cnt_reg <= 5'h00;
				rsp <= {1'b1, held_reg.tag, 1'b0, held_reg.is_read,
					held_reg.is_read ? ~held_reg.addr : 32'h0};
			end
		end
	end
endmodule : rpiso_link_model

/* rpiso_top_tb.sv */
// rpiso_top_tb: directed regression of rpiso_top
// assumes: package, link model and monitor compiled first
`timescale 1ns/10ps
module rpiso_top_tb;
	logic pclk = 1'b0, presetn = 1'b0, ce = 1'b1, link_down = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, mem_mute = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, lq;
	logic [3:0] lat = 4'h0;
	logic pready, pslverr, force_link_down, msi_req, err_cor_req, irq, lerr;
	logic mem_host_req_ready, cache_host_req_ready;
	logic mem_link_req_ready, cache_link_req_ready;
	rpiso_pkg::rpiso_req_t mem_host_req = '0, cache_host_req = '0;
	rpiso_pkg::rpiso_req_t mem_link_req, cache_link_req;
	rpiso_pkg::rpiso_rsp_t mem_link_rsp, cache_link_rsp;
	rpiso_pkg::rpiso_rsp_t mem_host_rsp, cache_host_rsp;
	int checks = 0, fails = 0, nmsi = 0, nerr = 0, nfwd = 0;
	rpiso_top u_dut (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .link_down, .force_link_down,
		.mem_host_req, .mem_host_req_ready, .mem_link_req,
		.mem_link_req_ready, .mem_link_rsp, .mem_host_rsp, .cache_host_req,
		.cache_host_req_ready, .cache_link_req, .cache_link_req_ready,
		.cache_link_rsp, .cache_host_rsp, .msi_req, .err_cor_req, .irq);
	rpiso_link_model u_mem (.pclk, .presetn, .req(mem_link_req),
		.ready(mem_link_req_ready), .rsp(mem_link_rsp), .lat, .mute(mem_mute));
	rpiso_link_model u_cache (.pclk, .presetn, .req(cache_link_req),
		.ready(cache_link_req_ready), .rsp(cache_link_rsp), .lat,
		.mute(1'b0));
	initial begin
		forever #12.5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		if (msi_req === 1'b1)
			nmsi++;
		if (err_cor_req === 1'b1)
			nerr++;
		if (mem_link_req.valid === 1'b1 && mem_link_req_ready === 1'b1)
			nfwd++;
	end
	// ========
	// tasks
	task automatic conclude;
		$display("checks=%0d fails=%0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : conclude
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic lim(input int n, input int m);
		if (n >= m) begin
			fails++;
			$display("CHECK FAILED t=%0t wait ran out", $time);
			conclude();
		end
	endtask : lim
	// trailing idle edge keeps psel from being driven twice at one edge
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 64);
		lim(n, 64);
		lq = prdata;
		lerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(lq, e);
	endtask : rd
	task automatic send(input logic p, input logic [3:0] t, input logic r,
		input logic [31:0] a);
		int n = 0;
		if (p)
			cache_host_req <= '{1'b1, t, r, a, ~a};
		else
			mem_host_req <= '{1'b1, t, r, a, ~a};
		do begin
			@(posedge pclk);
			n++;
		end while ((p ? cache_host_req_ready : mem_host_req_ready) !== 1'b1
			&& n < 64);
		lim(n, 64);
		cache_host_req.valid <= 1'b0;
		mem_host_req.valid <= 1'b0;
	endtask : send
	task automatic await_rsp(input logic p, input logic [3:0] t,
		input logic [31:0] ed, input logic [1:0] ef);
		int n = 0;
		rpiso_pkg::rpiso_rsp_t s;
		do begin
			@(posedge pclk);
			n++;
			s = p ? cache_host_rsp : mem_host_rsp;
		end while (s.valid !== 1'b1 && n < 200);
		lim(n, 200);
		chk(32'({s.tag, s.poison, s.has_data}), 32'({t, ef}));
		if (ef[0])
			chk(s.data, ed);
	endtask : await_rsp
	task automatic xfer(input logic p, input logic [3:0] t, input logic r,
		input logic [31:0] a, input logic [31:0] ed, input logic [1:0] ef);
		send(p, t, r, a);
		await_rsp(p, t, ed, ef);
	endtask : xfer
	// ========
	// sequence
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		link_down <= 1'b1;
		@(posedge pclk);
		rd(rpiso_pkg::OFF_CTRL, 32'h0);
		rd(rpiso_pkg::OFF_TMO, rpiso_pkg::TIMEOUT_CYC_DEF);
		rd(8'h40, 32'h0);
		chk(32'(lerr), 32'h1);
		rd(rpiso_pkg::OFF_STAT, 32'h0);
		// writes while frozen must be lost
		ce <= 1'b0;
		apb(1'b1, rpiso_pkg::OFF_IEN, 32'h3);
		ce <= 1'b1;
		rd(rpiso_pkg::OFF_IEN, 32'h0);
		link_down <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			lat <= 4'(i * 4);
			xfer(i[0], 4'(i), i < 2, 32'h100 << i, ~(32'h100 << i),
				2'(i < 2));
		end
		// short limit, still above the longest link model latency here
		apb(1'b1, rpiso_pkg::OFF_TMO, 32'd20);
		apb(1'b1, rpiso_pkg::OFF_IEN, 32'h3);
		apb(1'b1, rpiso_pkg::OFF_CTRL, 32'h3f);
		mem_mute <= 1'b1;
		send(1'b0, 4'h2, 1'b1, 32'h40);
		rd(rpiso_pkg::OFF_PEND, 32'h4);
		await_rsp(1'b0, 4'h2, rpiso_pkg::POISON_DATA, 2'b11);
		rd(rpiso_pkg::OFF_STAT, 32'h7);
		rd(rpiso_pkg::OFF_ICLR, 32'h3);
		chk(32'({irq, force_link_down}), 32'h3);
		chk({nmsi[15:0], nerr[15:0]}, 32'h0001_0001);
		lq = 32'(nfwd);
		xfer(1'b0, 4'h5, 1'b0, 32'h44, 32'h0, 2'b00);
		xfer(1'b0, 4'h6, 1'b1, 32'h48, rpiso_pkg::POISON_DATA, 2'b11);
		chk(32'(nfwd), lq);
		mem_mute <= 1'b0;
		apb(1'b1, rpiso_pkg::OFF_ICLR, 32'h3);
		chk(32'(irq), 32'h0);
		rd(rpiso_pkg::OFF_ICLR, 32'h0);
		rd(rpiso_pkg::OFF_STAT, 32'h7);
		apb(1'b1, rpiso_pkg::OFF_CTRL, 32'h40);
		apb(1'b0, rpiso_pkg::OFF_STAT, 32'h0);
		chk(lq, 32'h0);
		chk(32'(force_link_down), 32'h0);
		xfer(1'b0, 4'h7, 1'b1, 32'h4c, ~32'h4c, 2'b01);
		apb(1'b1, rpiso_pkg::OFF_CTRL, 32'h200);
		link_down <= 1'b1;
		apb(1'b0, rpiso_pkg::OFF_STAT, 32'h0);
		chk(lq & 32'h0a0a, 32'h0a00);
		chk(32'(irq), 32'h0);
		xfer(1'b1, 4'h9, 1'b0, 32'h90, 32'h0, 2'b00);
		apb(1'b1, rpiso_pkg::OFF_CTRL, 32'h202);
		apb(1'b0, rpiso_pkg::OFF_STAT, 32'h0);
		chk(lq & 32'h0a0a, 32'h0a0a);
		chk(32'(irq), 32'h1);
		conclude();
	end
endmodule : rpiso_top_tb
bind rpiso_top rpiso_monitor u_mon (.pclk, .presetn, .psel, .penable,
	.pwrite, .force_link_down, .mem_host_req, .mem_host_req_ready,
	.mem_link_req, .mem_host_rsp, .cache_host_req, .cache_host_req_ready,
	.cache_link_req, .cache_host_rsp, .msi_req);
